// [bench/utf_top_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module utf_top_tb_top;
	// Short bit time keeps every drain loop brief
	localparam int BITC = 2;
	localparam int DEP = utf_pkg::FIFO_DEPTH;
	// Bus and line signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, txd;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic err;
	logic [6:0] thr;
	logic [7:0] sb;	// Byte sent in the framing check
	logic [9:0] fr;	// Line samples of one frame
	int n_errors = 0;
	int compares = 0;
	// Fixed seed keeps runs repeatable
	int seed = 32'hD4C5;

	utf_top #(.DEPTH(DEP), .BIT_CYCLES(BITC)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Expected trigger count per select code
	function automatic logic [6:0] thr_of(input logic [1:0] s);
		case (s)
			2'h0: return 7'h08;
			2'h1: return 7'h04;
			2'h2: return 7'h02;
			default: return 7'h00;
		endcase
	endfunction

	// Compare and report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic test_done();
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One APB transfer; waits for pready with a bound, never a fixed count
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			check(32'h0, 32'h1);
		end
	endtask

	// Random byte into the transmit FIFO
	task automatic push_rand();
		apb(1'b1, utf_pkg::ADDR_TX_DATA, {24'h000000, 8'($random(seed))});
	endtask

	// Poll a status bit; status reads also arm the low flag clear
	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
			n++;
		end while (rv[b] !== v && n < 2000);
		check({31'h0, rv[b]}, {31'h0, v});
	endtask

	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
		check({30'h0, rv[6:5]}, 32'h3);
		apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
		check(rv, 32'h0);
		apb(1'b0, utf_pkg::ADDR_FIFO_CONTROL, 32'h0);
		check({30'h0, rv[5:4]}, {30'h0, utf_pkg::CTRL_THR_RESET});
		apb(1'b0, utf_pkg::ADDR_INT_ENABLE, 32'h0);
		check(rv, 32'h0);
		// Unmapped offset must be refused
		apb(1'b0, 8'h1C, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rv, 32'h0);
		// One random frame on the line, sampled half a cycle into each bit on falling edges
		check({31'h0, txd}, 32'h1);
		sb = 8'($random(seed));
		apb(1'b1, utf_pkg::ADDR_TX_DATA, {24'h000000, sb});
		@(negedge txd);
		@(negedge pclk);
		for (int k = 0; k < 10; k++) begin
			fr[k] = txd;
			repeat (BITC) @(negedge pclk);
		end
		check({22'h0, fr}, {22'h0, 1'b1, sb, 1'b0});
		// Every threshold code
		for (int s = 0; s < 4; s++) begin
			thr = thr_of(2'(s));
			apb(1'b1, utf_pkg::ADDR_FIFO_CONTROL, 32'(s) << 4);
			push_rand();
			apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
			check({31'h0, rv[6]}, 32'h0);
			repeat (int'(thr) + 3) push_rand();
			apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
			check({31'h0, rv[6:0] > thr}, 32'h1);
			// Write 1 disarms, then unarmed 0 must not clear
			apb(1'b1, utf_pkg::ADDR_STATUS, 32'h20);
			apb(1'b1, utf_pkg::ADDR_STATUS, 32'h0);
			apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
			check({31'h0, rv[5]}, 32'h1);
			apb(1'b1, utf_pkg::ADDR_STATUS, 32'h0);
			apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
			check({31'h0, rv[5]}, 32'h0);
			// Drain to the trigger level, then until done with the FIFO empty
			wait_bit(5, 1'b1);
			apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
			check({31'h0, rv[6:0] <= thr}, 32'h1);
			wait_bit(6, 1'b1);
			apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
			check(rv, 32'h0);
		end
		// Events latched while masked, irq stays low
		apb(1'b0, utf_pkg::ADDR_INT_STATUS, 32'h0);
		check({30'h0, rv[1:0]}, 32'h3);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, utf_pkg::ADDR_INT_ENABLE, 32'h7);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, utf_pkg::ADDR_INT_CLEAR, 32'h7);
		apb(1'b0, utf_pkg::ADDR_INT_STATUS, 32'h0);
		check(rv, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		// Overfill: excess bytes dropped, count caps at depth
		apb(1'b1, utf_pkg::ADDR_FIFO_CONTROL, 32'h30);
		repeat (DEP + 16) push_rand();
		apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
		check({31'h0, rv[6:0] <= 7'(DEP) && rv[6:0] >= 7'(DEP - 2)}, 32'h1);
		apb(1'b0, utf_pkg::ADDR_INT_STATUS, 32'h0);
		check({31'h0, rv[2]}, 32'h1);
		check({31'h0, irq}, 32'h1);
		wait_bit(6, 1'b1);
		apb(1'b0, utf_pkg::ADDR_FILL_COUNT, 32'h0);
		check(rv, 32'h0);
		test_done();
	end

	// Watchdog well beyond the expected run
	initial begin
		#(60000 * 5);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire

// [rtl/utf_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module utf_fifo #(
	parameter int DEPTH = utf_pkg::FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] pop_data,
	output logic [utf_pkg::CNT_W-1:0] count,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	// Pointer arithmetic wraps, so the depth must be a power of two
	if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("utf_fifo: DEPTH must be a power of two from 2 to 64");
	end

	logic [7:0] mem_ff [DEPTH];	// Byte storage
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [utf_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic do_push, do_pop;

	// Push into a full FIFO is lost; pop from empty is ignored
	always_comb begin
		do_push = push && !full;	// RQ9
		do_pop = pop && !empty;
		nxt_wr_ptr = do_push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = do_pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		nxt_cnt = cnt_ff;
		if (do_push && !do_pop) begin
			nxt_cnt = cnt_ff + 1'b1;	// RQ12
		end else if (do_pop && !do_push) begin
			nxt_cnt = cnt_ff - 1'b1;	// RQ12
		end
	end

	// Pointer and count registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem_ff[wr_ptr_ff] <= push_data;
		end
	end

	assign pop_data = mem_ff[rd_ptr_ff];
	assign count = cnt_ff;
	assign full = (cnt_ff == utf_pkg::CNT_W'(DEPTH));	// RQ8
	assign empty = (cnt_ff == '0);
endmodule
`default_nettype wire

// [rtl/utf_pkg.sv]
package utf_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] ADDR_TX_DATA = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_FILL_COUNT = 8'h0C;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INT_CLEAR = 8'h14;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h18;

	// Status register field positions
	localparam int STAT_LOW_BIT = 5;
	localparam int STAT_DONE_BIT = 6;

	// Threshold field position in the FIFO control register
	localparam int CTRL_THR_LSB = 4;
	localparam logic [1:0] CTRL_THR_RESET = 2'h0;

	// Interrupt status bits
	localparam int INT_DONE_BIT = 0;
	localparam int INT_LOW_BIT = 1;
	localparam int INT_DROP_BIT = 2;
	localparam int INT_W = 3;

	// Reset values of the two flags
	localparam logic DONE_RESET = 1'b1;
	localparam logic LOW_RESET = 1'b1;

	// FIFO geometry and fill count width
	localparam int FIFO_DEPTH = 64;
	localparam int CNT_W = 7;

	// Serial bit period in pclk cycles
	localparam int BIT_CYCLES = 16;

	// Trigger counts selected by the two threshold bits
	localparam logic [CNT_W-1:0] THR_SEL0 = 7'h08;
	localparam logic [CNT_W-1:0] THR_SEL1 = 7'h04;
	localparam logic [CNT_W-1:0] THR_SEL2 = 7'h02;
	localparam logic [CNT_W-1:0] THR_SEL3 = 7'h00;
	localparam logic [CNT_W-1:0] THR_MAX = 7'h08;

	// Shifter states
	typedef enum logic [1:0] {
		UTF_SH_IDLE = 2'b00,
		UTF_SH_START = 2'b01,
		UTF_SH_DATA = 2'b10,
		UTF_SH_STOP = 2'b11
	} utf_sh_state_t;

	// Decode the threshold field into a byte count
	function automatic logic [CNT_W-1:0] thr_count(input logic [1:0] sel);
		logic [CNT_W-1:0] val;
		case (sel)
			2'h0: val = THR_SEL0;
			2'h1: val = THR_SEL1;
			2'h2: val = THR_SEL2;
			default: val = THR_SEL3;
		endcase
		return val;
	endfunction

endpackage

// [rtl/utf_shifter.sv]
`timescale 1ns/10ps
`default_nettype none
module utf_shifter #(
	parameter int BIT_CYCLES = utf_pkg::BIT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic have_data,
	input wire logic [7:0] data,
	output logic take,
	output logic char_done,
	output logic txd
);
	if (BIT_CYCLES < 1 || BIT_CYCLES > 65535) begin : g_chk
		$error("utf_shifter: BIT_CYCLES out of range");
	end

	utf_pkg::utf_sh_state_t state_ff, nxt_state;
	logic [15:0] tick_ff, nxt_tick;	// Cycles left in the current bit
	logic [2:0] bit_ff, nxt_bit;	// Data bit index
	logic [7:0] sh_ff, nxt_sh;	// Shift register, LSB first
	logic txd_ff, nxt_txd;
	logic bit_end;

	// Frame sequencer: start bit, eight data bits, one stop bit
	always_comb begin
		bit_end = (tick_ff == '0);
		nxt_state = state_ff;
		nxt_tick = bit_end ? 16'(BIT_CYCLES - 1) : tick_ff - 1'b1;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		nxt_txd = txd_ff;
		take = 1'b0;
		char_done = 1'b0;
		case (state_ff)
			utf_pkg::UTF_SH_IDLE: begin
				nxt_txd = 1'b1;
				nxt_tick = 16'(BIT_CYCLES - 1);
				// Load the next byte as soon as one waits
				if (have_data) begin
					take = 1'b1;
					nxt_sh = data;
					nxt_txd = 1'b0;
					nxt_state = utf_pkg::UTF_SH_START;
				end
			end
			utf_pkg::UTF_SH_START: begin
				if (bit_end) begin
					nxt_txd = sh_ff[0];
					nxt_bit = 3'h0;
					nxt_state = utf_pkg::UTF_SH_DATA;
				end
			end
			utf_pkg::UTF_SH_DATA: begin
				if (bit_end) begin
					if (bit_ff == 3'h7) begin
						nxt_txd = 1'b1;
						nxt_state = utf_pkg::UTF_SH_STOP;
					end else begin
						nxt_sh = {1'b0, sh_ff[7:1]};
						nxt_txd = sh_ff[1];
						nxt_bit = bit_ff + 1'b1;
					end
				end
			end
			utf_pkg::UTF_SH_STOP: begin
				// Last bit of the character has gone out
				if (bit_end) begin
					char_done = 1'b1;
					nxt_state = utf_pkg::UTF_SH_IDLE;
				end
			end
			default: begin
				nxt_state = utf_pkg::UTF_SH_IDLE;
			end
		endcase
	end

	// Shifter registers; line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= utf_pkg::UTF_SH_IDLE;
			tick_ff <= '0;
			bit_ff <= '0;
			sh_ff <= '0;
			txd_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			tick_ff <= nxt_tick;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			txd_ff <= nxt_txd;
		end
	end

	assign txd = txd_ff;
endmodule
`default_nettype wire

// [rtl/utf_top.sv]
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1 - Done flag reads 1 after reset
// RQ2 - Done sets after last bit, FIFO empty
// RQ3 - Any data write clears done flag; a write in the same cycle as the done event leaves it set
// RQ4 - Low flag is 1 after reset
// RQ5 - Low flag sets when count drops to threshold
// RQ6 - Threshold comes from two control bits
// RQ7 - Low clears after refill and read-then-zero
// RQ8 - Transmit FIFO holds 64 bytes
// RQ9 - Writes into a full FIFO are dropped
// RQ10 - Fill count register shows FIFO occupancy
// RQ11 - Zero clears only after reading one
// RQ12 - Count tracks every push and pop
module utf_top #(
	parameter int DEPTH = utf_pkg::FIFO_DEPTH,
	parameter int BIT_CYCLES = utf_pkg::BIT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic txd
);
	// Threshold must stay below the FIFO size or the low flag never clears
	if (DEPTH <= int'(utf_pkg::THR_MAX)) begin : g_chk
		$error("utf_top: DEPTH must exceed the largest threshold");
	end

	// Bus handshake state
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic acc;	// Access phase completing this edge
	logic wr_data, wr_stat, wr_ctrl, wr_iclr, wr_ien, rd_stat;

	// Flags and software-visible control
	logic done_ff, nxt_done;
	logic low_ff, nxt_low;
	logic armed_ff, nxt_armed;	// Low flag was read as 1
	logic [1:0] thr_sel_ff, nxt_thr_sel;
	logic [utf_pkg::INT_W-1:0] ist_ff, nxt_ist;
	logic [utf_pkg::INT_W-1:0] ien_ff, nxt_ien;
	logic irq_ff, nxt_irq;

	// Datapath links
	logic [utf_pkg::CNT_W-1:0] count;
	logic [utf_pkg::CNT_W-1:0] thr;
	logic full, empty, take, char_done;
	logic [7:0] head;
	logic push, done_ev, low_ev, drop_ev;

	// Decode the address of a bus request
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		return a == reg_addr;
	endfunction

	// Transmit FIFO, 64 entries by default
	utf_fifo #( // RQ8
		.DEPTH(DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.push(push),
		.push_data(pwdata[7:0]),
		.pop(take),
		.pop_data(head),
		.count(count),
		.full(full),
		.empty(empty)
	);

	// Serialiser that drains the FIFO
	utf_shifter #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_shifter (
		.pclk(pclk),
		.presetn(presetn),
		.have_data(!empty),
		.data(head),
		.take(take),
		.char_done(char_done),
		.txd(txd)
	);

	// Request decode; effects happen only on the completing edge
	always_comb begin
		acc = psel && penable && pready_ff;
		wr_data = acc && pwrite && hit(paddr, utf_pkg::ADDR_TX_DATA);
		wr_stat = acc && pwrite && hit(paddr, utf_pkg::ADDR_STATUS);
		wr_ctrl = acc && pwrite && hit(paddr, utf_pkg::ADDR_FIFO_CONTROL);
		wr_iclr = acc && pwrite && hit(paddr, utf_pkg::ADDR_INT_CLEAR);
		wr_ien = acc && pwrite && hit(paddr, utf_pkg::ADDR_INT_ENABLE);
		rd_stat = acc && !pwrite && hit(paddr, utf_pkg::ADDR_STATUS);
		thr = utf_pkg::thr_count(thr_sel_ff);	// RQ6
		// A byte offered to a full FIFO is thrown away
		push = wr_data && !full;	// RQ9
		drop_ev = wr_data && full;	// RQ9
	end

	// APB slave: answer one cycle after setup, data prepared at setup
	always_comb begin
		nxt_pready = psel && !penable;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_prdata = 32'h0000_0000;
			case (paddr)
				utf_pkg::ADDR_TX_DATA: begin
					// Write-only; reads as zero
					nxt_prdata = 32'h0000_0000;
				end
				utf_pkg::ADDR_STATUS: begin
					nxt_prdata[utf_pkg::STAT_DONE_BIT] = done_ff;	// RQ1
					nxt_prdata[utf_pkg::STAT_LOW_BIT] = low_ff;
				end
				utf_pkg::ADDR_FIFO_CONTROL: begin
					nxt_prdata[utf_pkg::CTRL_THR_LSB +: 2] = thr_sel_ff;
				end
				utf_pkg::ADDR_FILL_COUNT: begin
					nxt_prdata[utf_pkg::CNT_W-1:0] = count;	// RQ10
				end
				utf_pkg::ADDR_INT_STATUS: begin
					nxt_prdata[utf_pkg::INT_W-1:0] = ist_ff;
				end
				utf_pkg::ADDR_INT_CLEAR: begin
					nxt_prdata = 32'h0000_0000;
				end
				utf_pkg::ADDR_INT_ENABLE: begin
					nxt_prdata[utf_pkg::INT_W-1:0] = ien_ff;
				end
				default: begin
					// Unmapped offset answers with an error
					nxt_pslverr = 1'b1;
				end
			endcase
		end else if (pready_ff) begin
			nxt_pslverr = 1'b0;
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// Transmit-done and FIFO-low flags; a set always beats a clear
	always_comb begin
		done_ev = char_done && empty;	// RQ2
		// Count after this cycle's pop, compared with the trigger
		low_ev = take && ((count - 1'b1) <= thr);	// RQ5 RQ12
		nxt_done = done_ff;
		if (done_ev) begin
			nxt_done = 1'b1;	// RQ2
		end else if (wr_data) begin
			nxt_done = 1'b0;	// RQ3
		end
		nxt_low = low_ff;
		nxt_armed = armed_ff;
		// Arm on the value the read returned, not on the flag at the access edge
		if (rd_stat && prdata_ff[utf_pkg::STAT_LOW_BIT]) begin
			nxt_armed = 1'b1;	// RQ11
		end
		if (low_ev) begin
			nxt_low = 1'b1;	// RQ5
		end else if (wr_stat && !pwdata[utf_pkg::STAT_LOW_BIT] && armed_ff && count > thr) begin
			nxt_low = 1'b0;	// RQ7 RQ11
		end
		// Any write to the status word consumes the earlier read
		if (wr_stat) begin
			nxt_armed = 1'b0;
		end
		nxt_thr_sel = wr_ctrl ? pwdata[utf_pkg::CTRL_THR_LSB +: 2] : thr_sel_ff;	// RQ6
	end

	// Flag registers; both flags come out of reset set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= utf_pkg::DONE_RESET;	// RQ1
			low_ff <= utf_pkg::LOW_RESET;	// RQ4
			armed_ff <= 1'b0;
			thr_sel_ff <= utf_pkg::CTRL_THR_RESET;
		end else begin
			done_ff <= nxt_done;
			low_ff <= nxt_low;
			armed_ff <= nxt_armed;
			thr_sel_ff <= nxt_thr_sel;
		end
	end

	// Sticky interrupt status; new events win over a clear
	always_comb begin
		nxt_ist = ist_ff;
		if (wr_iclr) begin
			nxt_ist = ist_ff & ~pwdata[utf_pkg::INT_W-1:0];
		end
		nxt_ist[utf_pkg::INT_DONE_BIT] = nxt_ist[utf_pkg::INT_DONE_BIT] | done_ev;
		nxt_ist[utf_pkg::INT_LOW_BIT] = nxt_ist[utf_pkg::INT_LOW_BIT] | low_ev;
		nxt_ist[utf_pkg::INT_DROP_BIT] = nxt_ist[utf_pkg::INT_DROP_BIT] | drop_ev;
		nxt_ien = wr_ien ? pwdata[utf_pkg::INT_W-1:0] : ien_ff;
		// Level output changes on the same edge as the enabled sticky bits
		nxt_irq = |(nxt_ist & nxt_ien);
	end

	// Interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_ff <= '0;
			ien_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			ist_ff <= nxt_ist;
			ien_ff <= nxt_ien;
			irq_ff <= nxt_irq;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Done falls after a data write with no end of character
	data_clears_done_a: assert property (wr_data && !done_ev |=> !done_ff) // RQ3
		else $error("done flag not cleared by data write");
	// Done rises after the last character leaves an empty FIFO
	done_on_end_a: assert property (char_done && empty |=> done_ff) // RQ2
		else $error("done flag not set at end of transmission");
	// Done never rises without its cause
	done_stays_low_a: assert property (!done_ff && !done_ev |=> !done_ff) // RQ1
		else $error("done flag rose without cause");
	// Low flag rises when a pop leaves the count at or under the trigger
	low_on_drain_a: assert property (take && count <= thr + 1'b1 |=> low_ff) // RQ5
		else $error("low flag not set on drain");
	// Read-one then write-zero with a refilled FIFO clears the flag
	low_clear_seq_a: assert property ( // RQ7
		armed_ff && wr_stat && !pwdata[utf_pkg::STAT_LOW_BIT]
		&& count > thr && !low_ev
		|=> !low_ff)
		else $error("low flag not cleared after read and zero write");
	// Write of zero without a prior read leaves the flag set
	low_needs_read_a: assert property (low_ff && wr_stat && !armed_ff |=> low_ff) // RQ11
		else $error("low flag cleared without a prior read");
	// Writing one to the status word never clears the flag
	low_write_one_a: assert property ( // RQ11
		low_ff && wr_stat && pwdata[utf_pkg::STAT_LOW_BIT] |=> low_ff)
		else $error("low flag cleared by writing one");
	// A byte offered to a full FIFO with no pop in the same cycle leaves the count unchanged
	full_drop_a: assert property (wr_data && full && !take |=> count == $past(count)) // RQ9
		else $error("write to full FIFO was stored");
	// Accepted write without a pop adds exactly one
	count_push_a: assert property (push && !take |=> count == $past(count) + 1'b1) // RQ12
		else $error("count did not follow a push");
	// Occupancy never passes the FIFO size
	depth_bound_a: assert property (count <= utf_pkg::CNT_W'(DEPTH)) // RQ8
		else $error("FIFO count exceeds depth");
	// Fill count read returns the count seen at setup
	fill_read_a: assert property ( // RQ10
		acc && !pwrite && paddr == utf_pkg::ADDR_FILL_COUNT
		|-> prdata[utf_pkg::CNT_W-1:0] == $past(count))
		else $error("fill count read mismatch");
	// Ready is a single-cycle answer per access
	pready_pulse_a: assert property (pready_ff |=> !pready_ff)
		else $error("pready held for more than one cycle");
	// Control write loads the threshold select
	thr_write_a: assert property ( // RQ6
		wr_ctrl |=> thr_sel_ff == $past(pwdata[utf_pkg::CTRL_THR_LSB +: 2]))
		else $error("threshold select not loaded");
	// Low flag only falls after an armed zero write with a refilled FIFO
	low_fall_cause_a: assert property ( // RQ7
		$fell(low_ff) |-> $past(armed_ff && wr_stat && count > thr))
		else $error("low flag fell without an armed clear");
	// Dropped write is recorded in the interrupt status
	drop_status_a: assert property (drop_ev |=> ist_ff[utf_pkg::INT_DROP_BIT]) // RQ9
		else $error("dropped write not recorded");
	// End of transmission is recorded in the interrupt status
	done_status_a: assert property (done_ev |=> ist_ff[utf_pkg::INT_DONE_BIT]) // RQ2
		else $error("end of transmission not recorded");

	// Main scenarios
	drop_seen_c: cover property (drop_ev);
	low_cleared_c: cover property (low_ff ##1 !low_ff);
	done_set_c: cover property (!done_ff ##1 done_ff);
	irq_seen_c: cover property (!irq_ff ##1 irq_ff);
	full_seen_c: cover property (full ##1 !full);
endmodule
`default_nettype wire
